// ==== hw/salm_alarm_mgr.sv ====
// Fault and warning manager: detection, latching, clearing and display of alarm codes
// How it works
// - Any fault turns fault indicator off, power stage off, shows the code.
// - A warning shows its code while the motor keeps running.
// - Alarm clears by host reset input, power cycle or keypad reset.
// - Parameter, overcurrent, system, phase and encoder alarms clear only by power cycle.
// - With run still on, the motor restarts the moment the alarm clears.
// - Front display steps through the code characters one position at a time.
// - Torque above 120 percent of rated raises the overload alarm.
// - Overload warning precedes the overload alarm and may escalate into it.
// - Regeneration overload warning precedes and may escalate to that alarm.
// - Position error beyond the programmed limit raises deviation overflow.
// - Speed above the maximum raises the overspeed alarm.
// - Rotation against the commanded direction raises the runaway alarm.
// - Encoder channel A, B or S open or shorted raises disconnection alarm.
// - Motor not matching the drive raises the parameter error alarm.
// - DC bus voltage out of range raises the voltage alarm.
// - Regenerative energy over resistor capacity raises regeneration overload.
// - Overcurrent or heat-sink overheating raises the overcurrent alarm.
// - Parameter unit link errors go only to the parameter unit.
`timescale 1ns/1ps
`default_nettype none
module salm_alarm_mgr #(
  parameter int DWELL_CYC = salm_pkg::SALM_DWELL_CYC
) (
  input  wire logic                signed [23:0] pos_err_in,
  input  wire logic                       [23:0] position_error_limit_param_in,
  input  wire logic                              ref_clk_in,
  input  wire logic                              reset_in,
  input  wire salm_pkg::salm_det_t               det_in,
  input  wire logic                       [9:0]  torque_pct_in,
  input  wire logic                       [9:0]  regen_load_in,
  input  wire logic                       [15:0] speed_in,
  input  wire logic                              alarm_reset_in,
  input  wire logic                              key_reset_in,
  input  wire logic                              run_cmd_in,
  input  wire logic                              pu_comm_fail_in,
  input  wire logic                              pu_timeout_in,
  output logic                                   fault_indicator_out,
  output logic                                   power_enable_out,
  output logic                            [7:0]  alarm_code_out,
  output logic                            [1:0]  pu_err_out,
  output logic                            [7:0]  seg_out
);
  localparam int NF = salm_pkg::SALM_NFLT;

  logic          alarm_reg, alarm_next;
  logic [7:0]    code_reg, code_next;
  logic          show_reg, show_next;
  logic [7:0]    disp_next;
  logic          fault_ind_next;
  logic          pwr_next;
  logic [NF-1:0] flt;
  logic          any_flt;
  logic [7:0]    new_code;
  logic [7:0]    warn_code;
  logic          clear_req;
  logic [23:0]   pos_abs;
  logic [9:0]    ol_load;
  logic          ol_warn, ol_trip;
  logic          rg_warn, rg_trip;

  // Overload model heats only on torque above rated
  always_comb
  begin
    ol_load = '0;
    if (torque_pct_in > salm_pkg::SALM_TORQUE_RATED)
      ol_load = torque_pct_in - salm_pkg::SALM_TORQUE_RATED;
  end

  salm_therm #(
    .ACC_W  (salm_pkg::SALM_ACC_W),
    .LOAD_W (10),
    .WARN   (salm_pkg::SALM_OL_WARN),
    .TRIP   (salm_pkg::SALM_OL_TRIP)
  ) u_ol (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .load_in    (ol_load),
    .warn_out   (ol_warn),
    .trip_out   (ol_trip)
  );

  // Regenerative energy against resistor capacity
  salm_therm #(
    .ACC_W  (salm_pkg::SALM_ACC_W),
    .LOAD_W (10),
    .WARN   (salm_pkg::SALM_RG_WARN),
    .TRIP   (salm_pkg::SALM_RG_TRIP)
  ) u_rg (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .load_in    (regen_load_in),
    .warn_out   (rg_warn),
    .trip_out   (rg_trip)
  );

  // Magnitude of the position error; most negative value reads as largest
  assign pos_abs = pos_err_in[23] ? 24'(-pos_err_in) : pos_err_in;

  // Fault detection into slots
  always_comb
  begin
    flt     = '0;
    flt[0]  = det_in.motor_mismatch;
    flt[1]  = det_in.overcurrent | det_in.heatsink_hot;
    flt[2]  = det_in.sys_err;
    flt[3]  = det_in.phase_err;
    flt[4]  = |det_in.enc_bad;
    flt[5]  = det_in.dc_bus_bad;
    flt[6]  = speed_in > salm_pkg::SALM_MAX_SPEED;
    flt[7]  = (torque_pct_in > salm_pkg::SALM_TORQUE_LIMIT) | ol_trip;
    flt[8]  = rg_trip;
    flt[9]  = det_in.regen_circuit_bad;
    flt[10] = det_in.overheat;
    flt[11] = det_in.moving & (det_in.dir_cmd != det_in.dir_motor);
    flt[12] = pos_abs > position_error_limit_param_in;
  end

  assign any_flt = |flt;

  // Lowest slot wins the code when faults coincide
  always_comb
  begin
    new_code = 8'h00;
    for (int i = NF - 1; i >= 0; i--)
    begin
      if (flt[i])
        new_code = salm_pkg::SALM_CODE[i];
    end
  end

  // Overload warning outranks regeneration warning
  always_comb
  begin
    warn_code = 8'h00;
    if (ol_warn)
      warn_code = salm_pkg::SALM_W_OVLD;
    else if (rg_warn)
      warn_code = salm_pkg::SALM_W_RGOVL;
  end

  // Host reset or keypad reset; power-only codes refuse both
  assign clear_req = (alarm_reset_in | key_reset_in) & ~salm_pkg::salm_power_only(code_reg);

  // Latch and clear; a fault present in the clearing cycle keeps the alarm
  always_comb
  begin
    alarm_next = alarm_reg;
    code_next  = code_reg;
    if (!alarm_reg)
    begin
      if (any_flt)
      begin
        alarm_next = 1'b1;
        code_next  = new_code;
      end
    end
    else if (clear_req)
    begin
      if (any_flt)
        code_next = new_code;
      else
      begin
        alarm_next = 1'b0;
        code_next  = 8'h00;
      end
    end
    // Otherwise the alarm holds with its code
    show_next      = alarm_next | (warn_code != 8'h00);
    disp_next      = alarm_next ? code_next : warn_code;
    fault_ind_next = ~alarm_next;
    // No handshake on restart: the host must drop run first, or the motor moves at once
    pwr_next       = run_cmd_in & ~alarm_next;
  end

  // Alarm state and all outputs except seg_out
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      alarm_reg           <= 1'b0;
      code_reg            <= 8'h00;
      show_reg            <= 1'b0;
      alarm_code_out      <= 8'h00;
      fault_indicator_out <= 1'b1;
      power_enable_out    <= 1'b0;
      pu_err_out          <= 2'b00;
    end
    else
    begin
      alarm_reg           <= alarm_next;
      code_reg            <= code_next;
      show_reg            <= show_next;
      alarm_code_out      <= disp_next;
      fault_indicator_out <= fault_ind_next;
      power_enable_out    <= pwr_next;
      pu_err_out          <= {pu_timeout_in, pu_comm_fail_in};
    end
  end

  // Front panel digit shows alarms and warnings, never link errors
  salm_disp_seq #(
    .DWELL_CYC (DWELL_CYC)
  ) u_disp (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .show_in    (show_reg),
    .code_in    (alarm_code_out),
    .seg_out    (seg_out)
  );

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  property p_fault_off;
    any_flt |=> !fault_indicator_out && !power_enable_out && (alarm_code_out != 8'h00);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault did not stop the drive");

  property p_warn_runs;
    !alarm_reg && !any_flt && ol_warn && run_cmd_in
      |=> power_enable_out && fault_indicator_out && (alarm_code_out == salm_pkg::SALM_W_OVLD);
  endproperty
  a_warn_runs: assert property (p_warn_runs) else $error("warning stopped the drive");

  property p_clear;
    alarm_reg && alarm_reset_in && !salm_pkg::salm_power_only(code_reg) && !any_flt
      |=> !alarm_reg && fault_indicator_out;
  endproperty
  a_clear: assert property (p_clear) else $error("alarm reset ignored");

  property p_power_only;
    alarm_reg && salm_pkg::salm_power_only(code_reg) |=> alarm_reg && $stable(code_reg);
  endproperty
  a_power_only: assert property (p_power_only) else $error("power-only alarm cleared");

  property p_restart;
    alarm_reg && key_reset_in && !salm_pkg::salm_power_only(code_reg) && !any_flt && run_cmd_in
      |=> power_enable_out;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after clear");

  property p_overload;
    !alarm_reg && (torque_pct_in > salm_pkg::SALM_TORQUE_LIMIT) && (flt[6:0] == '0)
      |=> alarm_reg && (code_reg == salm_pkg::SALM_C_OVLD);
  endproperty
  a_overload: assert property (p_overload) else $error("overload alarm missing");

  property p_deviation;
    !alarm_reg && (pos_abs > position_error_limit_param_in) && (flt[11:0] == '0)
      |=> alarm_reg && (code_reg == salm_pkg::SALM_C_DEV);
  endproperty
  a_deviation: assert property (p_deviation) else $error("deviation alarm missing");

  property p_encoder;
    !alarm_reg && (det_in.enc_bad != 3'b000) && (flt[3:0] == '0) |=> code_reg == salm_pkg::SALM_C_ENC;
  endproperty
  a_encoder: assert property (p_encoder) else $error("encoder alarm missing");

  property p_pu_only;
    !alarm_reg && !any_flt && (pu_comm_fail_in || pu_timeout_in)
      |=> !alarm_reg && fault_indicator_out && (pu_err_out != 2'b00);
  endproperty
  a_pu_only: assert property (p_pu_only) else $error("link error reached front panel");

  property p_hold;
    alarm_reg && !alarm_reset_in && !key_reset_in |=> alarm_reg && $stable(code_reg) && !power_enable_out;
  endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped without clear");

  property p_rg_warn_runs;
    !alarm_reg && !any_flt && rg_warn && !ol_warn && run_cmd_in
      |=> power_enable_out && fault_indicator_out && (alarm_code_out == salm_pkg::SALM_W_RGOVL);
  endproperty
  a_rg_warn_runs: assert property (p_rg_warn_runs) else $error("regeneration warning stopped the drive");

  property p_overspeed;
    !alarm_reg && (speed_in > salm_pkg::SALM_MAX_SPEED) && (flt[5:0] == '0)
      |=> alarm_reg && (code_reg == salm_pkg::SALM_C_OVSPD);
  endproperty
  a_overspeed: assert property (p_overspeed) else $error("overspeed alarm missing");

  property p_runaway;
    !alarm_reg && det_in.moving && (det_in.dir_cmd != det_in.dir_motor) && (flt[10:0] == '0)
      |=> alarm_reg && (code_reg == salm_pkg::SALM_C_RUNAW);
  endproperty
  a_runaway: assert property (p_runaway) else $error("runaway alarm missing");

  property p_param;
    !alarm_reg && det_in.motor_mismatch
      |=> alarm_reg && (code_reg == salm_pkg::SALM_C_PARAM);
  endproperty
  a_param: assert property (p_param) else $error("parameter alarm missing");

  property p_voltage;
    !alarm_reg && det_in.dc_bus_bad && (flt[4:0] == '0)
      |=> alarm_reg && (code_reg == salm_pkg::SALM_C_VOLT);
  endproperty
  a_voltage: assert property (p_voltage) else $error("bus voltage alarm missing");

endmodule : salm_alarm_mgr
`default_nettype wire

// ==== include/salm_pkg.sv ====
// Shared constants, codes and types of the servo alarm manager
package salm_pkg;

  // Clock and display timing
  localparam int SALM_CLK_HZ    = 125_000_000;
  localparam int SALM_DWELL_MS  = 500;
  localparam int SALM_DWELL_CYC = SALM_DWELL_MS * (SALM_CLK_HZ / 1000);

  // Alarm and warning codes, two display characters each
  localparam logic [7:0] SALM_C_PARAM = 8'h04;
  localparam logic [7:0] SALM_C_OVCUR = 8'h10;
  localparam logic [7:0] SALM_C_SYS   = 8'hbf;
  localparam logic [7:0] SALM_C_PHASE = 8'hc2;
  localparam logic [7:0] SALM_C_ENC   = 8'hc3;
  localparam logic [7:0] SALM_C_VOLT  = 8'h40;
  localparam logic [7:0] SALM_C_OVSPD = 8'h51;
  localparam logic [7:0] SALM_C_OVLD  = 8'h70;
  localparam logic [7:0] SALM_C_RGOVL = 8'h32;
  localparam logic [7:0] SALM_C_RGERR = 8'h30;
  localparam logic [7:0] SALM_C_HEAT  = 8'h7a;
  localparam logic [7:0] SALM_C_RUNAW = 8'hc1;
  localparam logic [7:0] SALM_C_DEV   = 8'hd0;
  localparam logic [7:0] SALM_W_OVLD  = 8'h91;
  localparam logic [7:0] SALM_W_RGOVL = 8'h92;

  // Fault slots; lower slot wins when several appear together
  localparam int SALM_NFLT = 13;
  localparam logic [7:0] SALM_CODE [SALM_NFLT] = '{
    SALM_C_PARAM, SALM_C_OVCUR, SALM_C_SYS, SALM_C_PHASE, SALM_C_ENC,
    SALM_C_VOLT, SALM_C_OVSPD, SALM_C_OVLD, SALM_C_RGOVL, SALM_C_RGERR,
    SALM_C_HEAT, SALM_C_RUNAW, SALM_C_DEV};

  // Detection thresholds
  localparam logic [9:0]  SALM_TORQUE_RATED = 10'h064;
  localparam logic [9:0]  SALM_TORQUE_LIMIT = 10'h078;
  localparam logic [15:0] SALM_MAX_SPEED    = 16'h1388;
  localparam int          SALM_ACC_W        = 24;
  localparam logic [23:0] SALM_OL_WARN      = 24'h010000;
  localparam logic [23:0] SALM_OL_TRIP      = 24'h020000;
  localparam logic [23:0] SALM_RG_WARN      = 24'h008000;
  localparam logic [23:0] SALM_RG_TRIP      = 24'h010000;

  // Segment patterns, bit 7 is the decimal point
  localparam logic [7:0] SALM_SEG_BLANK = 8'h00;
  localparam logic [7:0] SALM_SEG_A_DP  = 8'hf7;

  // Discrete fault detector levels
  typedef struct packed {
    logic       motor_mismatch;
    logic       overcurrent;
    logic       heatsink_hot;
    logic       sys_err;
    logic       phase_err;
    logic [2:0] enc_bad;
    logic       dc_bus_bad;
    logic       regen_circuit_bad;
    logic       overheat;
    logic       dir_cmd;
    logic       dir_motor;
    logic       moving;
  } salm_det_t;

  // Codes that only a power cycle removes
  function automatic logic salm_power_only(input logic [7:0] code);
    salm_power_only = (code == SALM_C_PARAM) || (code == SALM_C_OVCUR) ||
                      (code == SALM_C_SYS) || (code == SALM_C_PHASE) ||
                      (code == SALM_C_ENC);
  endfunction : salm_power_only

endpackage : salm_pkg

// ==== hw/salm_therm.sv ====
// Thermal style accumulator giving warning then trip
`timescale 1ns/1ps
`default_nettype none
module salm_therm #(
  parameter int               ACC_W  = 24,
  parameter int               LOAD_W = 10,
  parameter logic [ACC_W-1:0] WARN   = '1,
  parameter logic [ACC_W-1:0] TRIP   = '1
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  input  wire logic [LOAD_W-1:0] load_in,
  output logic                   warn_out,
  output logic                   trip_out
);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W:0]   sum;

  // Heats by the load input, cools by one per cycle without load; saturates at trip
  always_comb
  begin
    sum      = {1'b0, acc_reg} + (ACC_W+1)'(load_in);
    acc_next = acc_reg;
    if (load_in != '0)
      acc_next = (sum >= {1'b0, TRIP}) ? TRIP : sum[ACC_W-1:0];
    else if (acc_reg != '0)
      acc_next = acc_reg - 1'b1;
  end

  // State and flags
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      acc_reg  <= '0;
      warn_out <= 1'b0;
      trip_out <= 1'b0;
    end
    else
    begin
      acc_reg  <= acc_next;
      warn_out <= acc_next >= WARN;
      trip_out <= acc_next >= TRIP;
    end
  end
endmodule : salm_therm
`default_nettype wire

// ==== hw/salm_disp_seq.sv ====
// Single digit seven-segment sequencer for alarm codes
`timescale 1ns/1ps
`default_nettype none
module salm_disp_seq #(
  parameter int DWELL_CYC = salm_pkg::SALM_DWELL_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       show_in,
  input  wire logic [7:0] code_in,
  output logic      [7:0] seg_out
);
  typedef enum logic [2:0] {D_IDLE, D_LETTER, D_HI, D_LO, D_GAP} salm_dst_t;

  salm_dst_t   st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0]  code_reg, code_next;
  logic [7:0]  seg_next;
  logic        tick;

  // Hex character to segments
  function automatic logic [7:0] hex2seg(input logic [3:0] h);
    case (h)
      4'h0: hex2seg = 8'h3f;
      4'h1: hex2seg = 8'h06;
      4'h2: hex2seg = 8'h5b;
      4'h3: hex2seg = 8'h4f;
      4'h4: hex2seg = 8'h66;
      4'h5: hex2seg = 8'h6d;
      4'h6: hex2seg = 8'h7d;
      4'h7: hex2seg = 8'h07;
      4'h8: hex2seg = 8'h7f;
      4'h9: hex2seg = 8'h6f;
      4'ha: hex2seg = 8'h77;
      4'hb: hex2seg = 8'h7c;
      4'hc: hex2seg = 8'h39;
      4'hd: hex2seg = 8'h5e;
      4'he: hex2seg = 8'h79;
      default: hex2seg = 8'h71;
    endcase
  endfunction : hex2seg

  assign tick = (cnt_reg == 32'(DWELL_CYC - 1));

  // Steps A., high, low, gap; code is frozen per pass so one pass never mixes codes
  always_comb
  begin
    st_next   = st_reg;
    code_next = code_reg;
    cnt_next  = tick ? '0 : cnt_reg + 32'h1;
    case (st_reg)
      D_IDLE:
      begin
        cnt_next = '0;
        if (show_in)
        begin
          st_next   = D_LETTER;
          code_next = code_in;
        end
      end
      D_LETTER: if (tick) st_next = D_HI;
      D_HI:     if (tick) st_next = D_LO;
      D_LO:     if (tick) st_next = D_GAP;
      D_GAP:
      begin
        if (tick)
        begin
          st_next   = D_LETTER;
          code_next = code_in;
        end
      end
      default: st_next = D_IDLE;
    endcase
    if (!show_in)
    begin
      st_next  = D_IDLE;
      cnt_next = '0;
    end
    case (st_next)
      D_LETTER: seg_next = salm_pkg::SALM_SEG_A_DP;
      D_HI:     seg_next = hex2seg(code_next[7:4]);
      D_LO:     seg_next = hex2seg(code_next[3:0]);
      default:  seg_next = salm_pkg::SALM_SEG_BLANK;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      st_reg   <= D_IDLE;
      cnt_reg  <= '0;
      code_reg <= '0;
      seg_out  <= salm_pkg::SALM_SEG_BLANK;
    end
    else
    begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      code_reg <= code_next;
      seg_out  <= seg_next;
    end
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  property p_disp_order;
    (st_reg == D_HI) && tick && show_in |=> (st_reg == D_LO) && (seg_out == hex2seg(code_reg[3:0]));
  endproperty
  a_disp_order: assert property (p_disp_order) else $error("display skipped low character");

endmodule : salm_disp_seq
`default_nettype wire

// ==== dv/salm_host_model.sv ====
// Host position controller and parameter unit model driving the alarm manager's far-side inputs
`timescale 1ns/1ps
`default_nettype none
module salm_host_model (
  input  wire logic ref_clk_in,
  output logic      run_cmd_out,
  output logic      alarm_reset_out,
  output logic      key_reset_out,
  output logic      pu_comm_fail_out,
  output logic      pu_timeout_out
);
  // Idle levels from time zero; nothing asserted before reset is released
  initial
  begin
    run_cmd_out      = 1'b0;
    alarm_reset_out  = 1'b0;
    key_reset_out    = 1'b0;
    pu_comm_fail_out = 1'b0;
    pu_timeout_out   = 1'b0;
  end

  // Run command level, changed off the sampling edge
  task automatic set_run(input bit v);
    @(negedge ref_clk_in);
    run_cmd_out = v;
  endtask : set_run

  // Clear request; keep_run breaks the drop-run habit on purpose
  task automatic clear_alarm(input bit use_key, input bit keep_run, input int hold);
    if (!keep_run)
    begin
      @(negedge ref_clk_in);
      run_cmd_out = 1'b0;
    end
    @(negedge ref_clk_in);
    if (use_key)
      key_reset_out = 1'b1;
    else
      alarm_reset_out = 1'b1;
    // Slow or prompt release, chosen by the caller
    repeat (hold) @(negedge ref_clk_in);
    key_reset_out   = 1'b0;
    alarm_reset_out = 1'b0;
    if (!keep_run)
    begin
      @(negedge ref_clk_in);
      run_cmd_out = 1'b1;
    end
  endtask : clear_alarm

  // Parameter unit link error levels
  task automatic pu_link(input bit fail, input bit tmo);
    @(negedge ref_clk_in);
    pu_comm_fail_out = fail;
    pu_timeout_out   = tmo;
  endtask : pu_link
endmodule : salm_host_model
`default_nettype wire

// ==== dv/salm_alarm_mgr_tb_top.sv ====
// Self-checking bench of the servo alarm manager against an integer model
`timescale 1ns/1ps
`default_nettype none
module salm_alarm_mgr_tb_top;
  localparam int DWELL = 4;
  localparam logic [7:0] SLOT_CODE [13] = '{
    salm_pkg::SALM_C_PARAM, salm_pkg::SALM_C_OVCUR, salm_pkg::SALM_C_SYS, salm_pkg::SALM_C_PHASE,
    salm_pkg::SALM_C_ENC, salm_pkg::SALM_C_VOLT, salm_pkg::SALM_C_OVSPD, salm_pkg::SALM_C_OVLD,
    salm_pkg::SALM_C_RGERR, salm_pkg::SALM_C_HEAT, salm_pkg::SALM_C_RUNAW, salm_pkg::SALM_C_DEV,
    salm_pkg::SALM_C_OVCUR};
  logic                ref_clk_in = 1'b0;
  logic                reset_in   = 1'b1;
  logic signed [23:0]  pos_err;
  logic        [23:0]  lim;
  salm_pkg::salm_det_t det;
  logic        [9:0]   torque;
  logic        [9:0]   regen;
  logic        [15:0]  speed;
  wire logic           run, arst, krst, pcf, pto, fi, pe;
  wire logic   [7:0]   code, seg;
  wire logic   [1:0]   pue;
  int                  error_cnt = 0;
  int                  total_checks = 0;
  int                  seed;
  bit                  m_alarm;
  logic        [7:0]   m_code, cur_code;

  always #4 ref_clk_in = ~ref_clk_in;

  salm_host_model u_host (.ref_clk_in(ref_clk_in), .run_cmd_out(run), .alarm_reset_out(arst),
    .key_reset_out(krst), .pu_comm_fail_out(pcf), .pu_timeout_out(pto));

  salm_alarm_mgr #(.DWELL_CYC(DWELL)) u_dut (.pos_err_in(pos_err), .position_error_limit_param_in(lim),
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .det_in(det), .torque_pct_in(torque),
    .regen_load_in(regen), .speed_in(speed), .alarm_reset_in(arst), .key_reset_in(krst),
    .run_cmd_in(run), .pu_comm_fail_in(pcf), .pu_timeout_in(pto), .fault_indicator_out(fi),
    .power_enable_out(pe), .alarm_code_out(code), .pu_err_out(pue), .seg_out(seg));

  // Verdict and end of run, also reached on a timeout
  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  // Codes that the clear requests must leave alone
  function automatic bit pwr_only(input logic [7:0] c);
    return c inside {8'h04, 8'h10, 8'hbf, 8'hc2, 8'hc3};
  endfunction : pwr_only

  // Common seven-segment glyphs, dp in bit 7
  function automatic logic [7:0] glyph(input logic [3:0] h);
    logic [7:0] g [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                           8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
    return g[h];
  endfunction : glyph

  // Let outputs follow, then latch any present fault in the model
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk_in);
    if (!m_alarm && cur_code != 8'h00)
    begin
      m_alarm = 1'b1;
      m_code  = cur_code;
    end
  endtask : settle

  task automatic check_state;
    chk8("alarm_code", m_alarm ? m_code : 8'h00, code);
    chk1("fault_indicator", !m_alarm, fi);
    chk1("power_enable", run && !m_alarm, pe);
  endtask : check_state

  task automatic clear(input bit use_key, input bit keep_run);
    u_host.clear_alarm(use_key, keep_run, 1 + ($unsigned($random(seed)) % 3));
    if (m_alarm && !pwr_only(m_code))
      m_alarm = 1'b0;
    settle(2);
  endtask : clear

  task automatic do_reset;
    @(negedge ref_clk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    reset_in = 1'b0;
    m_alarm  = 1'b0;
    settle(2);
  endtask : do_reset

  // Bounded wait for a code or a segment pattern
  task automatic wait_val(input bit on_seg, input logic [7:0] v, input int bound);
    int n;
    n = 0;
    while ((on_seg ? seg : code) !== v)
    begin
      if (n == bound)
      begin
        error_cnt++;
        $display("MISMATCH wait_%s expected %h seen %h", on_seg ? "seg" : "code", v, on_seg ? seg : code);
        results();
      end
      @(negedge ref_clk_in);
      n++;
    end
  endtask : wait_val

  // One display pass from its start
  task automatic chk_disp(input logic [7:0] c);
    wait_val(1'b1, 8'h00, 64);
    wait_val(1'b1, salm_pkg::SALM_SEG_A_DP, 64);
    chk8("seg_a", salm_pkg::SALM_SEG_A_DP, seg);
    repeat (DWELL) @(negedge ref_clk_in);
    chk8("seg_hi", glyph(c[7:4]), seg);
    repeat (DWELL) @(negedge ref_clk_in);
    chk8("seg_lo", glyph(c[3:0]), seg);
    repeat (DWELL) @(negedge ref_clk_in);
    chk8("seg_blank", 8'h00, seg);
  endtask : chk_disp

  // Raise or drop one fault source
  task automatic set_fault(input int s, input bit on);
    case (s)
      0: det.motor_mismatch = on;
      1: det.overcurrent = on;
      2: det.sys_err = on;
      3: det.phase_err = on;
      4: det.enc_bad = on ? 3'h1 << ($unsigned($random(seed)) % 3) : 3'h0;
      5: det.dc_bus_bad = on;
      6: speed = on ? 16'h1389 + 16'($unsigned($random(seed)) % 256) : 16'h0064;
      7: torque = on ? 10'h079 : 10'h000;
      8: det.regen_circuit_bad = on;
      9: det.overheat = on;
      10:
      begin
        det.dir_cmd   = 1'($random(seed));
        det.moving    = 1'b1;
        det.dir_motor = det.dir_cmd ^ on;
      end
      11: pos_err = on ? -24'sh001001 : 24'sh001000;
      default: det.heatsink_hot = on;
    endcase
    cur_code = on ? SLOT_CODE[s] : 8'h00;
  endtask : set_fault

  // Main sequence
  initial
  begin
    seed = 38;
    det = '0;
    torque = 10'h000;
    regen = 10'h000;
    speed = 16'h0064;
    lim = 24'h001000;
    pos_err = 24'sh001000;
    m_alarm = 1'b0;
    cur_code = 8'h00;
    repeat (2) @(negedge ref_clk_in);
    check_state;
    chk8("seg", 8'h00, seg);
    chk8("pu_err", 8'h00, {6'h00, pue});
    reset_in = 1'b0;
    u_host.set_run(1'b1);
    settle(2);
    check_state;
    for (int s = 0; s < 13; s++)
    begin
      set_fault(s, 1'b1);
      settle(3);
      check_state;
      if (s == 6)
        chk_disp(SLOT_CODE[6]);
      set_fault(s, 1'b0);
      settle(3);
      check_state;
      clear(s % 2, 1'b0);
      check_state;
      if (m_alarm)
      begin
        do_reset;
        check_state;
      end
    end
    // Clear while the fault persists, then clear with run left on
    set_fault(5, 1'b1);
    settle(3);
    clear(1'b1, 1'b0);
    check_state;
    set_fault(5, 1'b0);
    settle(3);
    clear(1'b1, 1'b1);
    check_state;
    // Parameter unit link errors stay off the front indicator
    for (int k = 1; k < 4; k++)
    begin
      u_host.pu_link(k[0], k[1]);
      settle(3);
      chk8("pu_err", {6'h00, k[1:0]}, {6'h00, pue});
      check_state;
    end
    u_host.pu_link(1'b0, 1'b0);
    // Overload and regeneration warnings escalating to alarms
    torque = 10'h077;
    wait_val(1'b0, salm_pkg::SALM_W_OVLD, 40000);
    chk1("warn_power", 1'b1, pe);
    chk1("warn_indicator", 1'b1, fi);
    wait_val(1'b0, salm_pkg::SALM_C_OVLD, 40000);
    {m_alarm, m_code} = {1'b1, salm_pkg::SALM_C_OVLD};
    check_state;
    torque = 10'h000;
    do_reset;
    regen = 10'h3e8;
    wait_val(1'b0, salm_pkg::SALM_W_RGOVL, 2000);
    chk1("warn_power", 1'b1, pe);
    wait_val(1'b0, salm_pkg::SALM_C_RGOVL, 2000);
    {m_alarm, m_code} = {1'b1, salm_pkg::SALM_C_RGOVL};
    check_state;
    regen = 10'h000;
    do_reset;
    check_state;
    results();
  end
endmodule : salm_alarm_mgr_tb_top
`default_nettype wire
